// [core/addr_table_pkg.sv]
// constants, types and the hash shared by the address table files
// assumes a single switch core clock at 10 MHz
package addr_table_pkg;
	localparam int PORTS = 10;
	localparam int PORT_IDX_W = 4;
	localparam int ENTRIES = 8192;
	localparam int IDX_W = 13;
	localparam int ADDR_W = 48;
	localparam int VLAN_W = 12;
	localparam int KEY_W = VLAN_W + ADDR_W;
	localparam int AGE_W = 16;
	localparam int TICK_W = 24;
	// one-second tick for the age interval
	localparam longint SECOND_NS = 1000000000;
	localparam longint CLOCK_NS = 100;
	localparam int TICK_CYCLES = int'(SECOND_NS / CLOCK_NS);
	localparam logic [IDX_W-1:0] IDX_LAST = 13'h1FFF;
	localparam logic [AGE_W-1:0] AGE_RESET = 16'h0000;

	typedef enum logic [1:0] {K_EMPTY, K_DYNAMIC, K_STATIC, K_FILTER} kind_e;
	typedef enum logic [2:0] {
		OP_ADD_STATIC, OP_DEL_STATIC, OP_ADD_FILTER, OP_DEL_FILTER,
		OP_FLUSH_PORT, OP_READ_FIRST, OP_READ_NEXT
	} op_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [VLAN_W-1:0] vlan;
		logic [PORTS-1:0] ports;
		kind_e kind;
		logic hit;
	} entry_s;

	// fold address and vlan into a table slot
	function automatic logic [IDX_W-1:0] slot_of(
		input logic [ADDR_W-1:0] a, input logic [VLAN_W-1:0] v);
		slot_of = a[12:0] ^ a[25:13] ^ a[38:26] ^ {4'h0, a[47:39]}
			^ {1'b0, v};
	endfunction
endpackage

// [core/scan_if.sv]
// carrier between the table engine and its index walker
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface scan_if;
	import addr_table_pkg::*;
	logic start;
	logic busy;
	logic last;
	logic [IDX_W-1:0] idx;
	modport ctrl (output start, input busy, last, idx);
	modport walker (input start, output busy, last, idx);
endinterface
`default_nettype wire

// [core/table_walker.sv]
// index walker: visits every table slot once per start
// assumes start is only raised while not busy
`timescale 1ns/1ps
`default_nettype none
module table_walker (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// walk control
	scan_if.walker scan
);
	import addr_table_pkg::*;
	logic busy_q;
	logic [IDX_W-1:0] idx_q;

	// busy out of reset so the table is wiped before use
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_q <= 1'b1;
			idx_q <= '0;
		end else if (scan.start) begin
			busy_q <= 1'b1;
			idx_q <= '0;
		end else if (busy_q) begin
			busy_q <= (idx_q != IDX_LAST);
			idx_q <= idx_q + 1'b1;
		end
	end

	assign scan.busy = busy_q;
	assign scan.idx = idx_q;
	assign scan.last = busy_q && (idx_q == IDX_LAST);
endmodule // table_walker
`default_nettype wire

// [core/addr_table.sv]
// layer 2 address table: learning, ageing, static and filter entries,
// lookups and sorted readout; frames and commands come from logic on the
// same clock, so no input synchronisers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - each accepted frame learns or refreshes its source as a dynamic entry, unless its slot holds a static or filter entry
// - dynamic entries unseen for one age interval are removed
// - table holds 8192 entries
// - readout returns entries ascending by vlan then address
// - entry carries index, address, ports, vlan and type
// - port flush removes only dynamic entries learned on that port
// - static entries are never aged out
// - static entry is address, one port, vlan; forwards to that port
// - software adds, modifies and deletes static entries
// - frames matching a filter entry are dropped
// - software adds and deletes filter entries
module addr_table #(
	parameter int TICK_CYCLES = addr_table_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// frame in
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	input wire logic [addr_table_pkg::ADDR_W-1:0] source_station_address_i,
	input wire logic [addr_table_pkg::ADDR_W-1:0] dest_address_i,
	input wire logic [addr_table_pkg::VLAN_W-1:0] vlan_identifier_i,
	input wire logic [addr_table_pkg::PORT_IDX_W-1:0] rx_port_i,
	input wire logic [addr_table_pkg::PORTS-1:0] vlan_ports_i,
	// forwarding answer
	output logic fwd_valid_o,
	output logic fwd_drop_o,
	output logic [addr_table_pkg::PORTS-1:0] fwd_ports_o,
	// configuration
	input wire logic [addr_table_pkg::AGE_W-1:0] age_interval_i,
	// management command
	input wire logic cmd_valid_i,
	input wire addr_table_pkg::op_e cmd_op_i,
	input wire logic [addr_table_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [addr_table_pkg::VLAN_W-1:0] cmd_vlan_i,
	input wire logic [addr_table_pkg::PORT_IDX_W-1:0] cmd_port_i,
	// management answer
	output logic cmd_done_o,
	output logic cmd_ok_o,
	output logic [addr_table_pkg::IDX_W-1:0] rd_index_o,
	output logic [addr_table_pkg::ADDR_W-1:0] rd_addr_o,
	output logic [addr_table_pkg::PORTS-1:0] rd_ports_o,
	output logic [addr_table_pkg::VLAN_W-1:0] rd_vlan_o,
	output addr_table_pkg::kind_e rd_kind_o
);
	import addr_table_pkg::*;

	typedef enum logic [2:0] {
		ST_INIT, ST_IDLE, ST_SWEEP, ST_FLUSH, ST_DUMP
	} state_e;

	entry_s table_q [ENTRIES];

	scan_if scan ();
	table_walker u_walker (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.scan(scan.walker)
	);

	state_e state_q, state_d;
	logic ready_q, cmd_done_q, cmd_ok_q;
	logic fwd_valid_q, fwd_drop_q;
	logic [PORTS-1:0] fwd_ports_q, rd_ports_q;
	logic [IDX_W-1:0] rd_index_q, best_idx_q, best_idx_n;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [VLAN_W-1:0] rd_vlan_q;
	kind_e rd_kind_q;
	logic [KEY_W-1:0] prev_key_q, best_key_q, best_key_n, walk_key;
	logic have_prev_q, found_q, found_n, cand;
	logic [TICK_W-1:0] tick_q;
	logic [AGE_W-1:0] sec_q;
	logic sweep_pend_q, age_due;
	logic [IDX_W-1:0] src_idx, dst_idx, cmd_idx, wr_idx;
	entry_s src_e, dst_e, cmd_e, walk_e, wr_data;
	logic src_match, dst_match, src_locked, wr_en;
	logic frame_take, cmd_take, cmd_key_match;
	logic [PORTS-1:0] rx_bit, cmd_bit;

	// slot reads for the frame, the command and the walker
	assign src_idx = slot_of(source_station_address_i, vlan_identifier_i);
	assign dst_idx = slot_of(dest_address_i, vlan_identifier_i);
	assign cmd_idx = slot_of(cmd_addr_i, cmd_vlan_i);
	assign src_e = table_q[src_idx];
	assign dst_e = table_q[dst_idx];
	assign cmd_e = table_q[cmd_idx];
	assign walk_e = table_q[scan.idx];
	assign walk_key = {walk_e.vlan, walk_e.addr};
	assign rx_bit = PORTS'(1) << rx_port_i;
	assign cmd_bit = PORTS'(1) << cmd_port_i;
	assign src_match = (src_e.kind != K_EMPTY) && (src_e.vlan ==
		vlan_identifier_i) && (src_e.addr == source_station_address_i);
	assign dst_match = (dst_e.kind != K_EMPTY) && (dst_e.vlan ==
		vlan_identifier_i) && (dst_e.addr == dest_address_i);
	assign cmd_key_match = (cmd_e.kind != K_EMPTY) &&
		(cmd_e.vlan == cmd_vlan_i) && (cmd_e.addr == cmd_addr_i);
	// a foreign static or filter slot also blocks learning there
	assign src_locked = (src_e.kind == K_STATIC) || (src_e.kind == K_FILTER);

	// frames win over commands; a command is held until its done pulse
	assign frame_take = (state_q == ST_IDLE) && ready_q && frame_valid_i;
	assign cmd_take = (state_q == ST_IDLE) && cmd_valid_i && !frame_valid_i
		&& !cmd_done_q;

	// sequencing of walks
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_INIT, ST_SWEEP, ST_FLUSH, ST_DUMP: begin
				if (scan.last)
					state_d = ST_IDLE;
			end
			ST_IDLE: begin
				if (cmd_take && cmd_op_i == OP_FLUSH_PORT)
					state_d = ST_FLUSH;
				else if (cmd_take && (cmd_op_i == OP_READ_FIRST ||
					cmd_op_i == OP_READ_NEXT))
					state_d = ST_DUMP;
				else if (!frame_valid_i && !cmd_valid_i && sweep_pend_q)
					state_d = ST_SWEEP;
			end
			default: state_d = ST_INIT;
		endcase
	end
	assign scan.start = (state_q == ST_IDLE) && (state_d != ST_IDLE);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_INIT;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ready_q <= (state_d == ST_IDLE);
		end
	end

	// single table write port, one user per cycle
	always_comb begin
		wr_en = 1'b0;
		wr_idx = scan.idx;
		wr_data = walk_e;
		case (state_q)
			ST_INIT: begin
				wr_en = 1'b1;
				wr_data = '0;
			end
			ST_SWEEP: begin
				if (walk_e.kind == K_DYNAMIC) begin
					wr_en = 1'b1;
					if (!walk_e.hit)
						wr_data = '0;
					else
						wr_data.hit = 1'b0;
				end
			end
			ST_FLUSH: begin
				if (walk_e.kind == K_DYNAMIC && walk_e.ports == cmd_bit) begin
					wr_en = 1'b1;
					wr_data = '0;
				end
			end
			ST_IDLE: begin
				wr_idx = src_idx;
				if (frame_take && !src_locked) begin
					wr_en = 1'b1;
					wr_data = '{source_station_address_i, vlan_identifier_i,
						rx_bit, K_DYNAMIC, 1'b1};
				end else if (cmd_take) begin
					wr_idx = cmd_idx;
					case (cmd_op_i)
						// static add or modify, one port
						OP_ADD_STATIC: begin
							wr_en = cmd_key_match || cmd_e.kind == K_EMPTY ||
								cmd_e.kind == K_DYNAMIC;
							wr_data = '{cmd_addr_i, cmd_vlan_i, cmd_bit,
								K_STATIC, 1'b0};
						end
						OP_ADD_FILTER: begin
							wr_en = cmd_key_match || cmd_e.kind == K_EMPTY ||
								cmd_e.kind == K_DYNAMIC;
							wr_data = '{cmd_addr_i, cmd_vlan_i, '0,
								K_FILTER, 1'b0};
						end
						OP_DEL_STATIC: begin
							wr_en = cmd_key_match && cmd_e.kind == K_STATIC;
							wr_data = '0;
						end
						OP_DEL_FILTER: begin
							wr_en = cmd_key_match && cmd_e.kind == K_FILTER;
							wr_data = '0;
						end
						default: wr_en = 1'b0;
					endcase
				end
			end
			default: wr_en = 1'b0;
		endcase
	end

	// storage is wiped by the init walk, so no reset here
	always_ff @(posedge clock_i) begin
		if (wr_en)
			table_q[wr_idx] <= wr_data;
	end

	// forwarding answer one cycle after the frame
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fwd_valid_q <= 1'b0;
			fwd_drop_q <= 1'b0;
			fwd_ports_q <= '0;
		end else begin
			fwd_valid_q <= frame_take;
			if (frame_take) begin
				fwd_drop_q <= (dst_match && dst_e.kind == K_FILTER) ||
					(src_match && src_e.kind == K_FILTER);
				fwd_ports_q <= dst_match ? dst_e.ports
					: (vlan_ports_i & ~rx_bit);
			end
		end
	end

	// smallest key above the last one returned
	assign cand = (walk_e.kind != K_EMPTY) &&
		(!have_prev_q || walk_key > prev_key_q) &&
		(!found_q || walk_key < best_key_q);
	assign found_n = found_q || cand;
	assign best_key_n = cand ? walk_key : best_key_q;
	assign best_idx_n = cand ? scan.idx : best_idx_q;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			found_q <= 1'b0;
			best_key_q <= '0;
			best_idx_q <= '0;
			have_prev_q <= 1'b0;
			prev_key_q <= '0;
		end else if (cmd_take && cmd_op_i == OP_READ_FIRST) begin
			found_q <= 1'b0;
			have_prev_q <= 1'b0;
		end else if (cmd_take) begin
			found_q <= 1'b0;
		end else if (state_q == ST_DUMP) begin
			found_q <= found_n;
			best_key_q <= best_key_n;
			best_idx_q <= best_idx_n;
			if (scan.last && found_n) begin
				have_prev_q <= 1'b1;
				prev_key_q <= best_key_n;
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_done_q <= 1'b0;
			cmd_ok_q <= 1'b0;
			rd_index_q <= '0;
			rd_addr_q <= '0;
			rd_ports_q <= '0;
			rd_vlan_q <= '0;
			rd_kind_q <= K_EMPTY;
		end else begin
			cmd_done_q <= 1'b0;
			if (cmd_take && state_d == ST_IDLE) begin
				cmd_done_q <= 1'b1;
				cmd_ok_q <= wr_en;
			end else if (state_q == ST_FLUSH && scan.last) begin
				cmd_done_q <= 1'b1;
				cmd_ok_q <= 1'b1;
			end else if (state_q == ST_DUMP && scan.last) begin
				cmd_done_q <= 1'b1;
				cmd_ok_q <= found_n;
				rd_index_q <= best_idx_n;
				rd_addr_q <= table_q[best_idx_n].addr;
				rd_ports_q <= table_q[best_idx_n].ports;
				rd_vlan_q <= table_q[best_idx_n].vlan;
				rd_kind_q <= found_n ? table_q[best_idx_n].kind : K_EMPTY;
			end
		end
	end

	// age timer: entries live one to two intervals; zero stops ageing
	assign age_due = (tick_q == TICK_W'(TICK_CYCLES - 1)) &&
		(age_interval_i != AGE_RESET) && (sec_q >= age_interval_i - 1'b1);
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_q <= '0;
			sec_q <= AGE_RESET;
			sweep_pend_q <= 1'b0;
		end else begin
			tick_q <= (tick_q == TICK_W'(TICK_CYCLES - 1)) ? '0
				: tick_q + 1'b1;
			if (age_due)
				sec_q <= AGE_RESET;
			else if (tick_q == TICK_W'(TICK_CYCLES - 1))
				sec_q <= sec_q + 1'b1;
			// a new due wins over the sweep taking the old one
			if (age_due)
				sweep_pend_q <= 1'b1;
			else if (state_d == ST_SWEEP && state_q == ST_IDLE)
				sweep_pend_q <= 1'b0;
		end
	end

	assign frame_ready_o = ready_q;
	assign fwd_valid_o = fwd_valid_q;
	assign fwd_drop_o = fwd_drop_q;
	assign fwd_ports_o = fwd_ports_q;
	assign cmd_done_o = cmd_done_q;
	assign cmd_ok_o = cmd_ok_q;
	assign rd_index_o = rd_index_q;
	assign rd_addr_o = rd_addr_q;
	assign rd_ports_o = rd_ports_q;
	assign rd_vlan_o = rd_vlan_q;
	assign rd_kind_o = rd_kind_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	learn_write_a: assert property (
		frame_take && !src_locked |=> table_q[$past(src_idx)].kind
			== K_DYNAMIC && table_q[$past(src_idx)].hit)
		else $error("source not learned");
	age_delete_a: assert property (
		state_q == ST_SWEEP && walk_e.kind == K_DYNAMIC && !walk_e.hit
		|=> table_q[$past(scan.idx)].kind == K_EMPTY)
		else $error("stale entry kept");
	dump_order_a: assert property (
		state_q == ST_DUMP && scan.last && found_n && have_prev_q
		|-> best_key_n > prev_key_q)
		else $error("readout out of order");
	flush_port_a: assert property (
		state_q == ST_FLUSH && walk_e.kind != K_DYNAMIC
		|=> table_q[$past(scan.idx)] == $past(walk_e))
		else $error("flush touched other entry");
	static_keep_a: assert property (
		state_q == ST_SWEEP && walk_e.kind == K_STATIC
		|=> table_q[$past(scan.idx)].kind == K_STATIC)
		else $error("static entry aged");
	static_add_a: assert property (
		cmd_take && cmd_op_i == OP_ADD_STATIC && wr_en
		|=> cmd_done_o && cmd_ok_o && $onehot(table_q[$past(cmd_idx)].ports))
		else $error("static add wrong");
	filter_drop_a: assert property (
		frame_take && dst_match && dst_e.kind == K_FILTER
		|=> fwd_valid_o && fwd_drop_o)
		else $error("filtered frame passed");
	no_relearn_a: assert property (
		frame_take && src_locked
		|=> table_q[$past(src_idx)].kind == $past(src_e.kind))
		else $error("learning overwrote entry");
	flood_miss_a: assert property (
		frame_take && !dst_match
		|=> fwd_ports_o == ($past(vlan_ports_i) & ~$past(rx_bit)))
		else $error("miss not flooded");

	learn_seen_c: cover property (frame_take && !src_match && !src_locked);
	sweep_seen_c: cover property (state_q == ST_SWEEP && scan.last);
	dump_seen_c: cover property (state_q == ST_DUMP && scan.last && found_n);
endmodule // addr_table
`default_nettype wire

// [tb/ingress_model.sv]
// ingress pipeline model: offers one frame at a time to the table
// assumes the table takes a frame at an edge where ready was high
`timescale 1ns/1ps
`default_nettype none
module ingress_model (
	// clock
	input wire logic clock_i,
	// frame handshake
	input wire logic frame_ready_i,
	output logic frame_valid_o,
	output logic [addr_table_pkg::ADDR_W-1:0] src_o,
	output logic [addr_table_pkg::ADDR_W-1:0] dst_o,
	output logic [addr_table_pkg::VLAN_W-1:0] vlan_o,
	output logic [addr_table_pkg::PORT_IDX_W-1:0] port_o,
	output logic [addr_table_pkg::PORTS-1:0] vlan_ports_o
);
	import addr_table_pkg::*;

	// idle lines from time zero
	initial begin
		frame_valid_o = 1'b0;
		src_o = '0;
		dst_o = '0;
		vlan_o = '0;
		port_o = '0;
		vlan_ports_o = '0;
	end

	// hold the frame until a ready cycle has passed an edge
	task automatic send(input logic [ADDR_W-1:0] s, d,
		input logic [VLAN_W-1:0] v, input logic [PORT_IDX_W-1:0] p,
		input logic [PORTS-1:0] vp, output bit hung);
		int n;
		hung = 1'b1;
		@(negedge clock_i);
		frame_valid_o = 1'b1;
		src_o = s;
		dst_o = d;
		vlan_o = v;
		port_o = p;
		vlan_ports_o = vp;
		for (n = 0; n < 20000 && hung; n++) begin
			if (frame_ready_i === 1'b1)
				hung = 1'b0;
			else
				@(negedge clock_i);
		end
		@(negedge clock_i);
		// released lines other than port_o show the inverse, never a stale copy
		frame_valid_o = 1'b0;
		src_o = ~s;
		dst_o = ~d;
		vlan_o = ~v;
		vlan_ports_o = ~vp;
	endtask
endmodule // ingress_model
`default_nettype wire

// [tb/tb_addr_table.sv]
// self-checking bench for the address table engine
// assumes a short second tick so ageing sweeps fit the run
`timescale 1ns/1ps
`default_nettype none
module tb_addr_table;
	import addr_table_pkg::*;
	localparam int TICKS = 20;
	logic clock_i = 1'b0;
	logic resetn = 1'b0;
	logic fvalid, ready, fwd_valid, fwd_drop;
	logic [ADDR_W-1:0] src, dst, cmd_addr, rd_addr;
	logic [VLAN_W-1:0] vlan, cmd_vlan, rd_vlan;
	logic [PORT_IDX_W-1:0] rx_port, cmd_port;
	logic [PORTS-1:0] vports, fwd_ports, rd_ports, vp;
	logic [AGE_W-1:0] age = 16'h0000;
	logic cmd_valid = 1'b0;
	op_e cmd_op = OP_READ_FIRST;
	logic cmd_done, cmd_ok;
	logic [IDX_W-1:0] rd_index;
	kind_e rd_kind;
	int error_cnt = 0;
	int checks_done = 0;
	logic [ADDR_W-1:0] a, c, s, f, x;
	logic [KEY_W-1:0] ekey [4];
	logic [PORTS-1:0] ep [4];
	logic [IDX_W-1:0] ridx [3];
	op_e rop;
	kind_e ek [4];
	logic ok, was;
	int i, n, cnt;

	// clock at 10 MHz
	always #50 clock_i = ~clock_i;

	ingress_model i_ingress_model (.clock_i(clock_i),
		.frame_ready_i(ready), .frame_valid_o(fvalid), .src_o(src),
		.dst_o(dst), .vlan_o(vlan), .port_o(rx_port),
		.vlan_ports_o(vports));

	addr_table #(.TICK_CYCLES(TICKS)) i_addr_table (.clock_i(clock_i),
		.resetn_i(resetn), .frame_valid_i(fvalid), .frame_ready_o(ready),
		.source_station_address_i(src), .dest_address_i(dst),
		.vlan_identifier_i(vlan), .rx_port_i(rx_port),
		.vlan_ports_i(vports), .fwd_valid_o(fwd_valid),
		.fwd_drop_o(fwd_drop), .fwd_ports_o(fwd_ports),
		.age_interval_i(age), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
		.cmd_addr_i(cmd_addr), .cmd_vlan_i(cmd_vlan),
		.cmd_port_i(cmd_port), .cmd_done_o(cmd_done), .cmd_ok_o(cmd_ok),
		.rd_index_o(rd_index), .rd_addr_o(rd_addr), .rd_ports_o(rd_ports),
		.rd_vlan_o(rd_vlan), .rd_kind_o(rd_kind));

	// expected port sets
	function automatic logic [PORTS-1:0] hot(input int p);
		return PORTS'(1) << p;
	endfunction
	function automatic logic [PORTS-1:0] flood(input int p);
		return vp & ~hot(p);
	endfunction
	function automatic logic [ADDR_W-1:0] rnd48();
		return ADDR_W'({$urandom(), $urandom()});
	endfunction

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic fail(input string m);
		error_cnt++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk_ports(input logic [PORTS-1:0] e, g);
		checks_done++;
		if (g !== e) fail("port set mismatch");
	endtask
	task automatic chk_flag(input logic e, g);
		checks_done++;
		if (g !== e) fail("flag mismatch");
	endtask
	task automatic chk_key(input logic [KEY_W-1:0] e, g);
		checks_done++;
		if (g !== e) fail("entry key mismatch");
	endtask
	task automatic chk_kind(input kind_e e, g);
		checks_done++;
		if (g !== e) fail("entry type mismatch");
	endtask

	// one frame through the model, answer looked at in its pulse cycle
	task automatic frame(input logic [ADDR_W-1:0] sa, da,
		input logic [VLAN_W-1:0] v, input int p,
		input logic [PORTS-1:0] e, input logic drop);
		bit hung;
		i_ingress_model.send(sa, da, v, PORT_IDX_W'(p), vp, hung);
		if (hung) begin
			fail("frame never taken");
			test_done();
		end
		chk_flag(1'b1, fwd_valid);
		chk_flag(drop, fwd_drop);
		if (!drop)
			chk_ports(e, fwd_ports);
	endtask

	// level request held until the done pulse is seen
	task automatic cmd(input op_e op, input logic [ADDR_W-1:0] ka,
		input logic [VLAN_W-1:0] kv, input int p, output logic r);
		int k;
		@(negedge clock_i);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = ka;
		cmd_vlan = kv;
		cmd_port = PORT_IDX_W'(p);
		for (k = 0; k < 10000 && cmd_done !== 1'b1; k++)
			@(negedge clock_i);
		if (cmd_done !== 1'b1) begin
			fail("command never done");
			test_done();
		end
		r = cmd_ok;
		cmd_valid = 1'b0;
		cmd_addr = ~ka;
		cmd_vlan = ~kv;
	endtask

	initial begin
		cmd_addr = '0;
		cmd_vlan = '0;
		cmd_port = '0;
		void'($urandom(32'hfbb5_d013));
		a = rnd48();
		c = rnd48();
		s = rnd48();
		f = rnd48();
		x = rnd48();
		vp = PORTS'($urandom());
		repeat (8) @(negedge clock_i);
		resetn = 1'b1;
		// wipe takes the whole table, so wait with a bound
		for (n = 0; n < 9000 && ready !== 1'b1; n++)
			@(negedge clock_i);
		frame(a, x, 12'h001, 3, flood(3), 1'b0);
		frame(c, a, 12'h001, 5, hot(3), 1'b0);
		$display("test learn done");
		cmd(OP_ADD_STATIC, s, 12'h002, 6, ok);
		chk_flag(1'b1, ok);
		cmd(OP_ADD_STATIC, s, 12'h002, 7, ok);
		chk_flag(1'b1, ok);
		cmd(OP_DEL_STATIC, f, 12'h002, 0, ok);
		chk_flag(1'b0, ok);
		frame(s, s, 12'h002, 1, hot(7), 1'b0);
		frame(s, s, 12'h002, 1, hot(7), 1'b0);
		$display("test static done");
		cmd(OP_ADD_FILTER, f, 12'h001, 0, ok);
		chk_flag(1'b1, ok);
		frame(c, f, 12'h001, 5, '0, 1'b1);
		cmd(OP_DEL_FILTER, f, 12'h001, 0, ok);
		chk_flag(1'b1, ok);
		cmd(OP_DEL_FILTER, f, 12'h001, 0, ok);
		chk_flag(1'b0, ok);
		frame(c, f, 12'h001, 5, flood(5), 1'b0);
		$display("test filter done");
		// sorted readout: vlan 1 pair by address, then the static one
		ekey[0] = (a < c) ? {12'h001, a} : {12'h001, c};
		ekey[1] = (a < c) ? {12'h001, c} : {12'h001, a};
		ekey[2] = {12'h002, s};
		ep[0] = (a < c) ? hot(3) : hot(5);
		ep[1] = (a < c) ? hot(5) : hot(3);
		ep[2] = hot(7);
		ek = '{K_DYNAMIC, K_DYNAMIC, K_STATIC, K_EMPTY};
		for (i = 0; i < 4; i++) begin
			// first read restarts the walk, later ones step on
			rop = OP_READ_NEXT;
			if (i == 0)
				rop = OP_READ_FIRST;
			cmd(rop, '0, '0, 0, ok);
			chk_flag(i < 3, ok);
			chk_kind(ek[i], rd_kind);
			if (i < 3) begin
				chk_key(ekey[i], {rd_vlan, rd_addr});
				chk_ports(ep[i], rd_ports);
				ridx[i] = rd_index;
			end
		end
		// three live entries must report three different slots
		ok = (ridx[0] != ridx[1]) && (ridx[1] != ridx[2]) &&
			(ridx[0] != ridx[2]);
		chk_flag(1'b1, ok);
		$display("test readout done");
		cmd(OP_FLUSH_PORT, '0, '0, 3, ok);
		chk_flag(1'b1, ok);
		frame(c, a, 12'h001, 5, flood(5), 1'b0);
		frame(c, c, 12'h001, 5, hot(5), 1'b0);
		$display("test flush done");
		// three sweeps: first clears the seen mark, second removes
		age = 16'h0001;
		cnt = 0;
		was = 1'b1;
		for (n = 0; n < 40000 && cnt < 3; n++) begin
			@(negedge clock_i);
			if (was === 1'b1 && ready === 1'b0)
				cnt++;
			was = ready;
		end
		age = 16'h0000;
		if (cnt < 3) begin
			fail("ageing sweeps missing");
			test_done();
		end
		frame(x, c, 12'h001, 2, flood(2), 1'b0);
		frame(x, s, 12'h002, 2, hot(7), 1'b0);
		$display("test ageing done");
		// a deleted static entry no longer steers traffic
		cmd(OP_DEL_STATIC, s, 12'h002, 0, ok);
		chk_flag(1'b1, ok);
		frame(x, s, 12'h002, 2, flood(2), 1'b0);
		$display("test delete done");
		test_done();
	end
endmodule // tb_addr_table
`default_nettype wire
